// *** pkg/spcl_pkg.sv ***
package spcl_pkg;

  // Four-level strap codes
  localparam logic [1:0] LVL_ZERO  = 2'h0;
  localparam logic [1:0] LVL_THIRD = 2'h1;
  localparam logic [1:0] LVL_TWO3  = 2'h2;
  localparam logic [1:0] LVL_FULL  = 2'h3;

  // Three-level strap codes, 2'h3 is treated as mid
  localparam logic [1:0] TRI_ZERO  = 2'h0;
  localparam logic [1:0] TRI_MID   = 2'h1;
  localparam logic [1:0] TRI_FULL  = 2'h2;

  // Register map
  localparam logic [4:0]  MEDIA_CONFIG_DEFAULTS_ADDR = 5'h1E;
  localparam logic [15:0] MEDIA_CONFIG_RESET         = 16'h0000;

  // Field positions in media_config_defaults
  localparam int BIT_COPPER_SHORT   = 2;
  localparam int BIT_COPPER_IF      = 3;
  localparam int BIT_COPPER_LOWDRV  = 4;
  localparam int BIT_FIBRE_SHORT    = 5;
  localparam int BIT_FIBRE_FIBRE_LONG_WAVELENGTH   = 6;
  localparam int BIT_FIBRE_IF       = 7;
  localparam int BIT_TEN_MEG        = 8;
  localparam int BIT_SINGLE_RATE    = 9;
  localparam int BIT_FD_SUPPRESS    = 10;
  localparam int BIT_TRANSP_DIS     = 11;
  localparam int BIT_SCRAM_DIS      = 12;
  localparam int BIT_AUTONEG_DIS    = 14;
  localparam int BIT_HD_SUPPRESS    = 15;

  // Power-up sampling delay
  localparam int CLK_MHZ         = 125;
  localparam int SAMPLE_DELAY_US = 4;
  localparam int SAMPLE_CYCLES   = SAMPLE_DELAY_US * CLK_MHZ;

  typedef struct packed {
    logic [1:0] addr_top_warn_strap;
    logic [1:0] addr_mid_strap;
    logic [1:0] addr_low_strap;
    logic [1:0] copper_if_strap;
    logic [1:0] fibre_if_strap;
    logic [1:0] duplex_strap;
    logic [1:0] speed_strap;
  } spcl_straps_t;

  typedef struct packed {
    logic       we;
    logic [4:0] addr;
    logic [15:0] wdata;
  } spcl_mgmt_req_t;

  typedef enum logic [2:0] {
    MODE_FORCED_10,
    MODE_FORCED_100,
    MODE_NT_HALF,
    MODE_NT_FULL,
    MODE_TRANSPARENT
  } spcl_mode_t;

endpackage : spcl_pkg

// *** verilog/spcl_loader.sv ***
`timescale 1ns/1ps
// Contract
// - Low and mid address straps map 0,1/3,2/3,full to 00,10,11,01.
// - Top strap sets address bit 4 high at upper levels; warning at middle two.
// - Copper strap sets interface, short reach and low drive default bits.
// - Twisted pair enables scrambler unless management bit disables it.
// - Ten-metre copper reach bypasses input equalization.
// - Fibre strap sets interface, short reach and long wavelength default bits.
// - 300 m fibre reach raises signal-detect thresholds.
// - Duplex strap sets transparent-disable and full-duplex-suppress defaults.
// - Strap defaults stay writable; management writes replace them.
// - Straps sampled once shortly after power-up, later changes ignored.
// - Operating mode comes from duplex and speed straps together.
// - With warning enabled, transmitter off 425 ms per 3.8 s when one link down; the loader only drives o_link_integrity_warning.
// - Speed strap sets autoneg-disable, single-rate and ten-meg defaults.
module spcl_loader (
  input  wire logic                   i_clk_sys,
  input  wire logic                   i_rstn,
  input  wire spcl_pkg::spcl_straps_t i_straps,
  input  wire spcl_pkg::spcl_mgmt_req_t i_mgmt,
  output logic [15:0]                 o_mgmt_rdata,
  output logic [4:0]                  o_mgmt_addr,
  output logic                        o_link_integrity_warning,
  output logic                        o_straps_loaded,
  output logic                        o_scrambler_en,
  output logic                        o_eq_bypass,
  output logic                        o_sd_high_thresh,
  output spcl_pkg::spcl_mode_t        o_mode
);

  // Three-level decode, unused code reads as mid
  function automatic logic [1:0] tri_lvl(input logic [1:0] c);
    tri_lvl = (c == 2'h3) ? spcl_pkg::TRI_MID : c;
  endfunction : tri_lvl

  // Four-level address pair decode
  function automatic logic [1:0] addr_pair(input logic [1:0] c);
    case (c)
      spcl_pkg::LVL_ZERO:  addr_pair = 2'h0;
      spcl_pkg::LVL_THIRD: addr_pair = 2'h2;
      spcl_pkg::LVL_TWO3:  addr_pair = 2'h3;
      default:             addr_pair = 2'h1;
    endcase
  endfunction : addr_pair

  logic [9:0]           cnt_ff;
  logic [9:0]           nxt_cnt;
  logic                 done_ff;
  logic                 nxt_done;
  logic [15:0]          reg_ff;
  logic [15:0]          nxt_reg;
  logic [4:0]           addr_ff;
  logic [4:0]           nxt_addr;
  logic                 warn_ff;
  logic                 nxt_warn;
  spcl_pkg::spcl_mode_t mode_ff;
  spcl_pkg::spcl_mode_t nxt_mode;
  logic [15:0]          rdata_ff;
  logic [15:0]          nxt_rdata;
  logic [15:0]          strap_val;
  logic [1:0]           dup;
  logic [1:0]           spd;
  logic                 sample;

  assign sample = !done_ff && (cnt_ff == 10'(spcl_pkg::SAMPLE_CYCLES - 1));
  assign dup    = tri_lvl(i_straps.duplex_strap);
  assign spd    = tri_lvl(i_straps.speed_strap);

  always_comb begin
    strap_val = spcl_pkg::MEDIA_CONFIG_RESET;
    strap_val[spcl_pkg::BIT_COPPER_IF]     = (i_straps.copper_if_strap == spcl_pkg::LVL_THIRD);
    strap_val[spcl_pkg::BIT_COPPER_SHORT]  = i_straps.copper_if_strap[1];
    strap_val[spcl_pkg::BIT_COPPER_LOWDRV] = (i_straps.copper_if_strap == spcl_pkg::LVL_TWO3);
    strap_val[spcl_pkg::BIT_FIBRE_IF]      = (i_straps.fibre_if_strap == spcl_pkg::LVL_THIRD);
    strap_val[spcl_pkg::BIT_FIBRE_SHORT]   = (i_straps.fibre_if_strap == spcl_pkg::LVL_FULL);
    strap_val[spcl_pkg::BIT_FIBRE_FIBRE_LONG_WAVELENGTH]  =
      (i_straps.fibre_if_strap == spcl_pkg::LVL_TWO3);
    strap_val[spcl_pkg::BIT_TRANSP_DIS]    = (dup != spcl_pkg::TRI_MID);
    strap_val[spcl_pkg::BIT_FD_SUPPRESS]   = (dup == spcl_pkg::TRI_ZERO);
    strap_val[spcl_pkg::BIT_AUTONEG_DIS]   = (spd != spcl_pkg::TRI_MID);
    strap_val[spcl_pkg::BIT_SINGLE_RATE]   = (spd != spcl_pkg::TRI_MID);
    strap_val[spcl_pkg::BIT_TEN_MEG]       = (spd == spcl_pkg::TRI_ZERO);
  end

  always_comb begin
    nxt_cnt   = cnt_ff;
    nxt_done  = done_ff;
    nxt_reg   = reg_ff;
    nxt_addr  = addr_ff;
    nxt_warn  = warn_ff;
    nxt_mode  = mode_ff;
    nxt_rdata = (i_mgmt.addr == spcl_pkg::MEDIA_CONFIG_DEFAULTS_ADDR) ? reg_ff : 16'h0000;
    if (!done_ff) begin
      nxt_cnt = cnt_ff + 10'h001;
    end
    if (sample) begin
      nxt_done = 1'b1;
      nxt_reg  = strap_val;
      nxt_addr = {i_straps.addr_top_warn_strap[1],
                  addr_pair(i_straps.addr_mid_strap),
                  addr_pair(i_straps.addr_low_strap)};
      nxt_warn = (i_straps.addr_top_warn_strap == spcl_pkg::LVL_THIRD) ||
                 (i_straps.addr_top_warn_strap == spcl_pkg::LVL_TWO3);
      case (spd)
        spcl_pkg::TRI_ZERO: nxt_mode = spcl_pkg::MODE_FORCED_10;
        spcl_pkg::TRI_FULL: nxt_mode = spcl_pkg::MODE_FORCED_100;
        default: begin
          case (dup)
            spcl_pkg::TRI_ZERO: nxt_mode = spcl_pkg::MODE_NT_HALF;
            spcl_pkg::TRI_FULL: nxt_mode = spcl_pkg::MODE_NT_FULL;
            default:            nxt_mode = spcl_pkg::MODE_TRANSPARENT;
          endcase
        end
      endcase
    end else if (done_ff && i_mgmt.we &&
                 i_mgmt.addr == spcl_pkg::MEDIA_CONFIG_DEFAULTS_ADDR) begin
      nxt_reg = i_mgmt.wdata;
    end
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rstn) begin
      cnt_ff   <= 10'h000;
      done_ff  <= 1'b0;
      reg_ff   <= spcl_pkg::MEDIA_CONFIG_RESET;
      addr_ff  <= 5'h00;
      warn_ff  <= 1'b0;
      mode_ff  <= spcl_pkg::MODE_TRANSPARENT;
      rdata_ff <= 16'h0000;
    end else begin
      cnt_ff   <= nxt_cnt;
      done_ff  <= nxt_done;
      reg_ff   <= nxt_reg;
      addr_ff  <= nxt_addr;
      warn_ff  <= nxt_warn;
      mode_ff  <= nxt_mode;
      rdata_ff <= nxt_rdata;
    end
  end

  assign o_mgmt_rdata             = rdata_ff;
  assign o_mgmt_addr              = addr_ff;
  assign o_link_integrity_warning = warn_ff;
  assign o_straps_loaded          = done_ff;
  assign o_mode                   = mode_ff;
  assign o_scrambler_en   = !reg_ff[spcl_pkg::BIT_COPPER_IF] &&
                            !reg_ff[spcl_pkg::BIT_SCRAM_DIS];
  assign o_eq_bypass      = !reg_ff[spcl_pkg::BIT_COPPER_IF] &&
                            reg_ff[spcl_pkg::BIT_COPPER_SHORT] &&
                            !reg_ff[spcl_pkg::BIT_COPPER_LOWDRV];
  assign o_sd_high_thresh = !reg_ff[spcl_pkg::BIT_FIBRE_IF] &&
                            reg_ff[spcl_pkg::BIT_FIBRE_SHORT];

  chk_load_once: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    done_ff |=> done_ff && $stable(addr_ff) && $stable(warn_ff))
    else $error("strap values changed after load");
  chk_load_time: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(done_ff) |-> $past(cnt_ff) == 10'(spcl_pkg::SAMPLE_CYCLES - 1))
    else $error("load at wrong cycle");
  chk_warn_levels: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample |=> warn_ff == (addr_ff[4] ^ $past(i_straps.addr_top_warn_strap[0])))
    else $error("warning enable wrong");
  chk_addr_low: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.addr_low_strap == spcl_pkg::LVL_FULL |=> addr_ff[1:0] == 2'h1)
    else $error("low address decode wrong");
  chk_copper_short: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.copper_if_strap == spcl_pkg::LVL_TWO3 |=>
      reg_ff[4:2] == 3'h5)
    else $error("copper defaults wrong");
  chk_fibre_bits: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.fibre_if_strap == spcl_pkg::LVL_FULL |=> reg_ff[7:5] == 3'h1)
    else $error("fibre defaults wrong");
  chk_duplex_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && dup == spcl_pkg::TRI_ZERO |=> reg_ff[11:10] == 2'h3 && !reg_ff[15])
    else $error("duplex defaults wrong");
  chk_speed_full: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && spd == spcl_pkg::TRI_FULL |=> reg_ff[14] && reg_ff[9] && !reg_ff[8])
    else $error("speed defaults wrong");
  chk_mgmt_write: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    done_ff && i_mgmt.we && i_mgmt.addr == spcl_pkg::MEDIA_CONFIG_DEFAULTS_ADDR |=>
      reg_ff == $past(i_mgmt.wdata))
    else $error("management write lost");
  chk_mode_forced: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && spd == spcl_pkg::TRI_ZERO |=> o_mode == spcl_pkg::MODE_FORCED_10)
    else $error("mode decode wrong");
  chk_addr_mid_third: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.addr_mid_strap == spcl_pkg::LVL_THIRD |=>
      addr_ff[3:2] == 2'h2)
    else $error("mid address decode wrong");
  chk_addr_mid_two3: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.addr_mid_strap == spcl_pkg::LVL_TWO3 |=>
      addr_ff[3:2] == 2'h3)
    else $error("mid address decode wrong");
  chk_addr_low_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.addr_low_strap == spcl_pkg::LVL_ZERO |=>
      addr_ff[1:0] == 2'h0)
    else $error("low address decode wrong");
  chk_addr_top_low: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && (i_straps.addr_top_warn_strap == spcl_pkg::LVL_ZERO ||
               i_straps.addr_top_warn_strap == spcl_pkg::LVL_THIRD) |=> !addr_ff[4])
    else $error("address bit 4 wrong");
  chk_addr_top_high: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && (i_straps.addr_top_warn_strap == spcl_pkg::LVL_TWO3 ||
               i_straps.addr_top_warn_strap == spcl_pkg::LVL_FULL) |=> addr_ff[4])
    else $error("address bit 4 wrong");
  chk_warn_ends: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && (i_straps.addr_top_warn_strap == spcl_pkg::LVL_ZERO ||
               i_straps.addr_top_warn_strap == spcl_pkg::LVL_FULL) |=> !warn_ff)
    else $error("warning enabled at end level");
  chk_copper_pecl: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.copper_if_strap == spcl_pkg::LVL_THIRD |=>
      reg_ff[4:2] == 3'h2)
    else $error("copper defaults wrong");
  chk_copper_long: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.copper_if_strap == spcl_pkg::LVL_FULL |=>
      reg_ff[4:2] == 3'h1)
    else $error("copper defaults wrong");
  chk_copper_std: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.copper_if_strap == spcl_pkg::LVL_ZERO |=>
      reg_ff[4:2] == 3'h0)
    else $error("copper defaults wrong");
  chk_fibre_pecl: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.fibre_if_strap == spcl_pkg::LVL_THIRD |=>
      reg_ff[7:5] == 3'h4)
    else $error("fibre defaults wrong");
  chk_fibre_fibre_long_wavelength: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.fibre_if_strap == spcl_pkg::LVL_TWO3 |=>
      reg_ff[7:5] == 3'h2)
    else $error("fibre defaults wrong");
  chk_duplex_mid: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && dup == spcl_pkg::TRI_MID |=>
      reg_ff[11:10] == 2'h0 && !reg_ff[15])
    else $error("duplex defaults wrong");
  chk_duplex_full: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && dup == spcl_pkg::TRI_FULL |=>
      reg_ff[11:10] == 2'h2 && !reg_ff[15])
    else $error("duplex defaults wrong");
  chk_duplex_unused: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.duplex_strap == 2'h3 |=>
      reg_ff[11:10] == 2'h0)
    else $error("unused duplex code not mid");
  chk_speed_zero: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && spd == spcl_pkg::TRI_ZERO |=>
      reg_ff[14] && reg_ff[9] && reg_ff[8])
    else $error("speed defaults wrong");
  chk_speed_mid: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && spd == spcl_pkg::TRI_MID |=>
      !reg_ff[14] && !reg_ff[9] && !reg_ff[8])
    else $error("speed defaults wrong");
  chk_mode_fast: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && spd == spcl_pkg::TRI_FULL |=>
      o_mode == spcl_pkg::MODE_FORCED_100)
    else $error("mode decode wrong");
  chk_mode_half: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && spd == spcl_pkg::TRI_MID && dup == spcl_pkg::TRI_ZERO |=>
      o_mode == spcl_pkg::MODE_NT_HALF)
    else $error("mode decode wrong");
  chk_mode_full: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && spd == spcl_pkg::TRI_MID && dup == spcl_pkg::TRI_FULL |=>
      o_mode == spcl_pkg::MODE_NT_FULL)
    else $error("mode decode wrong");
  chk_mode_transp: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && spd == spcl_pkg::TRI_MID && dup == spcl_pkg::TRI_MID |=>
      o_mode == spcl_pkg::MODE_TRANSPARENT)
    else $error("mode decode wrong");
  chk_mode_held: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    done_ff |=>
      $stable(mode_ff))
    else $error("mode changed after load");
  chk_scram_default: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    $rose(done_ff) && !reg_ff[spcl_pkg::BIT_COPPER_IF] |->
      o_scrambler_en)
    else $error("scrambler not enabled on twisted pair");
  chk_scram_off: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    reg_ff[spcl_pkg::BIT_SCRAM_DIS] |->
      !o_scrambler_en)
    else $error("scrambler disable ignored");
  chk_eq_bypass: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.copper_if_strap == spcl_pkg::LVL_FULL |=>
      o_eq_bypass)
    else $error("equalizer not bypassed");
  chk_eq_kept: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.copper_if_strap == spcl_pkg::LVL_TWO3 |=>
      !o_eq_bypass)
    else $error("equalizer bypassed wrongly");
  chk_sd_raised: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.fibre_if_strap == spcl_pkg::LVL_FULL |=>
      o_sd_high_thresh)
    else $error("signal detect threshold not raised");
  chk_sd_normal: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && i_straps.fibre_if_strap == spcl_pkg::LVL_TWO3 |=>
      !o_sd_high_thresh)
    else $error("signal detect threshold raised wrongly");
  chk_early_write: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    !done_ff && !sample |=>
      reg_ff == spcl_pkg::MEDIA_CONFIG_RESET)
    else $error("register changed before load");
  chk_other_addr: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    done_ff && i_mgmt.we && i_mgmt.addr != spcl_pkg::MEDIA_CONFIG_DEFAULTS_ADDR |=>
      $stable(reg_ff))
    else $error("write to other address landed");
  chk_read_data: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_mgmt.addr == spcl_pkg::MEDIA_CONFIG_DEFAULTS_ADDR |=>
      o_mgmt_rdata == $past(reg_ff))
    else $error("read data wrong");
  chk_read_other: assert property (@(posedge i_clk_sys) disable iff (!i_rstn)
    i_mgmt.addr != spcl_pkg::MEDIA_CONFIG_DEFAULTS_ADDR |=>
      o_mgmt_rdata == 16'h0000)
    else $error("read of other address not zero");

  cov_load:       cover property (@(posedge i_clk_sys) disable iff (!i_rstn) $rose(done_ff));
  cov_write:      cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    done_ff && i_mgmt.we);
  cov_transp:     cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    sample && spd == spcl_pkg::TRI_MID && dup == spcl_pkg::TRI_MID);
  cov_warn:       cover property (@(posedge i_clk_sys) disable iff (!i_rstn) $rose(warn_ff));
  cov_refused:    cover property (@(posedge i_clk_sys) disable iff (!i_rstn)
    done_ff && i_mgmt.we && i_mgmt.addr != spcl_pkg::MEDIA_CONFIG_DEFAULTS_ADDR);

endmodule : spcl_loader

// *** tb/spcl_host.sv ***
`timescale 1ns/1ps
module spcl_host (
  input  wire logic                i_clk_sys,
  output spcl_pkg::spcl_straps_t   o_straps,
  output spcl_pkg::spcl_mgmt_req_t o_mgmt
);
  initial begin
    o_straps = '0;
    o_mgmt   = '0;
  end
  // Board strap levels, changed at the falling edge
  task automatic set_straps(input logic [13:0] lvl);
    @(negedge i_clk_sys);
    o_straps = lvl;
  endtask : set_straps
  // Host writes or reads a whole word
  task automatic put(input logic we, input logic [4:0] addr, input logic [15:0] data);
    @(negedge i_clk_sys);
    o_mgmt = {we, addr, data};
  endtask : put
  // Released request lines drop write enable and show the inverse of the last address and data
  task automatic idle();
    @(negedge i_clk_sys);
    o_mgmt = {1'b0, ~o_mgmt.addr, ~o_mgmt.wdata};
  endtask : idle
endmodule : spcl_host

// *** tb/testbench.sv ***
`timescale 1ns/1ps
module testbench;
  typedef struct packed {
    logic [13:0] straps;
    logic [4:0]  addr;
    logic        warn;
    logic [15:0] cfg;
    logic [2:0]  mode;
    logic [2:0]  misc;
  } spcl_row_t;
  localparam spcl_row_t ROWS [6] = '{
    {14'h0000, 5'h00, 1'h0, 16'h4F00, 3'h0, 3'h4},
    {14'h1555, 5'h0A, 1'h1, 16'h0088, 3'h4, 3'h0},
    {14'h2AAA, 5'h1F, 1'h1, 16'h4A54, 3'h1, 3'h4},
    {14'h3FFF, 5'h15, 1'h0, 16'h0024, 3'h4, 3'h7},
    {14'h0001, 5'h00, 1'h0, 16'h0C00, 3'h2, 3'h4},
    {14'h0009, 5'h00, 1'h0, 16'h0800, 3'h3, 3'h4}};
  logic                     i_clk_sys = 1'b0;
  logic                     i_rstn    = 1'b0;
  spcl_pkg::spcl_straps_t   straps;
  spcl_pkg::spcl_mgmt_req_t mgmt;
  logic [15:0]              rdata;
  logic [4:0]               maddr;
  logic                     warn, loaded, scr, eq, sd;
  spcl_pkg::spcl_mode_t     mode;
  int                       fails, num_checks, cycles, n;
  always #4 i_clk_sys = ~i_clk_sys;
  spcl_host i_host (.i_clk_sys(i_clk_sys), .o_straps(straps), .o_mgmt(mgmt));
  spcl_loader i_dut (.i_clk_sys(i_clk_sys), .i_rstn(i_rstn), .i_straps(straps),
    .i_mgmt(mgmt), .o_mgmt_rdata(rdata), .o_mgmt_addr(maddr),
    .o_link_integrity_warning(warn), .o_straps_loaded(loaded), .o_scrambler_en(scr),
    .o_eq_bypass(eq), .o_sd_high_thresh(sd), .o_mode(mode));
  task automatic stop_test();
    $display("checks %0d mismatches %0d", num_checks, fails);
    if (fails == 0 && num_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : stop_test
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    num_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk
  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    i_host.put(1'b0, a, 16'h0000);
    @(negedge i_clk_sys);
    chk(rdata, exp);
  endtask : rd
  // Reset, then count edges until the straps load; a write is tried meanwhile
  task automatic start(input logic [13:0] lvl);
    i_host.set_straps(lvl);
    i_rstn = 1'b0;
    repeat (20) @(negedge i_clk_sys);
    chk({loaded, scr, 11'h0, mode}, 16'h4004);
    i_rstn = 1'b1;
    i_host.put(1'b1, 5'h1E, 16'hFFFF);
    n = 1;
    while (loaded !== 1'b1 && n < 600) begin
      i_host.idle();
      n++;
    end
    chk(16'(n), 16'(spcl_pkg::SAMPLE_CYCLES));
  endtask : start
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 9000) begin
      fails++;
      stop_test();
    end
  end
  initial begin
    for (int r = 0; r < 6; r++) begin
      start(ROWS[r].straps);
      chk(16'(maddr), 16'(ROWS[r].addr));
      chk(16'(warn), 16'(ROWS[r].warn));
      chk(16'(mode), 16'(ROWS[r].mode));
      chk(16'({scr, eq, sd}), 16'(ROWS[r].misc));
      rd(5'h1E, ROWS[r].cfg);
      i_host.set_straps(~ROWS[r].straps);
      repeat (3) @(negedge i_clk_sys);
      chk(16'({maddr, warn, mode}), 16'({ROWS[r].addr, ROWS[r].warn, ROWS[r].mode}));
      rd(5'h1E, ROWS[r].cfg);
    end
    i_host.put(1'b1, 5'h1E, 16'h00E0);
    rd(5'h1E, 16'h00E0);
    i_host.put(1'b1, 5'h1E, 16'h0014);
    rd(5'h1E, 16'h0014);
    chk(16'({scr, eq, sd}), 16'h4);
    i_host.put(1'b1, 5'h1E, 16'h0004);
    i_host.put(1'b1, 5'h01, 16'hFFFF);
    rd(5'h1E, 16'h0004);
    chk(16'({scr, eq, sd}), 16'h6);
    rd(5'h01, 16'h0000);
    i_host.put(1'b1, 5'h1E, 16'h1020);
    rd(5'h1E, 16'h1020);
    chk(16'({scr, eq, sd}), 16'h1);
    stop_test();
  end
endmodule : testbench
